/* File: gdrv_cfg_pkg.sv */
// Constants, types and carriers of the gate-driver configuration bank.
// Assumes one 100 MHz clock shared with the serial front end.
package gdrv_cfg_pkg;
  localparam int CLK_MHZ = 100;
  localparam int RELOAD_TIME_US = 125;
  // Longest time, 125 us at 100 MHz, gives exactly 12500 cycles
  localparam int RELOAD_CYC = RELOAD_TIME_US * CLK_MHZ;
  localparam int CNT_W = 24;
  // Register offsets
  localparam logic [6:0] A_CONF0 = 7'h00;
  localparam logic [6:0] A_CONF2 = 7'h02;
  localparam logic [6:0] A_CONF3 = 7'h03;
  localparam logic [6:0] A_CONF4 = 7'h04;
  localparam logic [6:0] A_CONF7 = 7'h07;
  localparam logic [6:0] A_LOCK = 7'h08;
  localparam logic [6:0] A_AOSEL = 7'h10;
  localparam logic [6:0] A_CSG = 7'h11;
  localparam logic [6:0] A_FSDL = 7'h12;
  localparam logic [6:0] A_DTI = 7'h13;
  localparam logic [6:0] A_DTIF = 7'h14;
  localparam logic [6:0] A_WDRST = 7'h15;
  localparam logic [6:0] A_BIAS = 7'h16;
  localparam logic [6:0] A_RELOAD = 7'h17;
  localparam logic [6:0] A_FLAGA = 7'h20;
  localparam logic [6:0] A_FLAGB = 7'h21;
  localparam logic [6:0] A_LINK = 7'h22;
  localparam logic [6:0] A_BK0 = 7'h40;
  localparam logic [6:0] A_BK3 = 7'h43;
  // Values
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_AOSEL = 8'h07;
  localparam logic [7:0] CMD_GO = 8'h00;
  localparam logic [7:0] CMD_WD = 8'h00;
  localparam logic [7:0] CMD_UNLATCH = 8'hFF;
  localparam logic [7:0] LINK_PAT = 8'h55;
  // Field positions in supply_diagnostic_output_pin_config
  localparam int B_THERM = 5;
  localparam int B_CLRSEL = 4;
  localparam int B_LATONLY = 3;
  localparam int B_POL = 2;
  localparam int B_VGSEL = 1;
  localparam int B_VCSEL = 0;
  // Field positions in otp_readout_bias
  localparam int B_BIAS_EN = 1;
  localparam int B_BIAS_LV = 0;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00, ST_REQ = 2'b01, ST_WAIT = 2'b10, ST_HOLD = 2'b11
  } reload_state_t;
  typedef enum logic [1:0] {
    THR_NORMAL = 2'b00, THR_LOW = 2'b01, THR_HIGH = 2'b10
  } otp_thr_t;
  typedef struct packed {
    logic valid;
    logic write;
    logic [6:0] addr;
    logic [7:0] wdata;
  } acc_req_t;
  typedef struct packed {
    logic valid;
    logic [7:0] status;
    logic [7:0] rdata;
  } acc_rsp_t;
endpackage : gdrv_cfg_pkg

/* File: gdrv_cfg_bank.sv */
// Configuration and diagnostic register bank of a three-phase pre-driver.
// Assumes a serial front end on clk that issues one access per request.
`timescale 1ns/1ps
module gdrv_cfg_bank #(
  parameter int RELOAD_CYCLES = gdrv_cfg_pkg::RELOAD_CYC
) (
  input wire logic clk,
  input wire logic nrst,
  input wire gdrv_cfg_pkg::acc_req_t acc_req,
  output gdrv_cfg_pkg::acc_rsp_t acc_rsp,
  input wire logic [1:0] op_mode,
  input wire logic dt_update_busy,
  input wire logic enable_pin,
  input wire logic [4:0] fault_cond_a,
  input wire logic [4:0] fault_cond_b,
  input wire logic latch_fault,
  output logic otp_rd_en,
  output logic [1:0] otp_rd_word,
  output gdrv_cfg_pkg::otp_thr_t otp_threshold,
  input wire logic [7:0] otp_rd_data,
  input wire logic otp_rd_done,
  output logic [7:0] cfg_byte [0:7],
  output logic [7:0] aout_sel,
  output logic [7:0] cs_gain,
  output logic [7:0] fet_short_lvl,
  output logic [7:0] dead_time,
  output logic thermal_limit_select,
  output logic gate_supply_mode_select,
  output logic regulator_level_select,
  output logic diagnostic_output_pin,
  output logic wd_restart,
  output logic latch_release
);
  gdrv_cfg_pkg::reload_state_t state_q;
  gdrv_cfg_pkg::otp_thr_t thr_q;
  logic [1:0] word_q;
  logic [gdrv_cfg_pkg::CNT_W-1:0] cnt_q;
  logic [7:0] prot_q [0:2];
  logic [7:0] main_q [4:7];
  logic [7:0] bk_q [0:3];
  logic [1:0] bias_q;
  logic otp_lock_q;
  logic main_lock_q;
  logic acc_fail_q;
  logic latch_q;
  logic diagnostic_output_pin_sum_q;
  logic [4:0] flag_a_q;
  logic [4:0] flag_b_q;
  logic [11:0] sync1_q;
  logic [11:0] sync2_q;
  logic en_low;
  logic [4:0] cond_a;
  logic [4:0] cond_b;
  logic latch_in;
  logic busy;
  logic load;
  logic wr;
  logic rd;
  logic fail;
  logic wr_ok;
  logic en_ok;
  logic [7:0] rdata;
  logic [7:0] status;
  logic diagnostic_output_pin_err;

  // Address decode shared by the permission and answer logic
  function automatic logic is_mapped(input logic [6:0] a);
    return (a <= gdrv_cfg_pkg::A_LOCK) ||
           (a >= gdrv_cfg_pkg::A_AOSEL && a <= gdrv_cfg_pkg::A_RELOAD) ||
           (a >= gdrv_cfg_pkg::A_FLAGA && a <= gdrv_cfg_pkg::A_LINK) ||
           (a >= gdrv_cfg_pkg::A_BK0 && a <= gdrv_cfg_pkg::A_BK3);
  endfunction : is_mapped

  function automatic logic is_otp_grp(input logic [6:0] a);
    return (a <= gdrv_cfg_pkg::A_CONF2) ||
           (a >= gdrv_cfg_pkg::A_BK0 && a <= gdrv_cfg_pkg::A_BK3);
  endfunction : is_otp_grp

  function automatic logic is_main_grp(input logic [6:0] a);
    return a >= gdrv_cfg_pkg::A_CONF4 && a <= gdrv_cfg_pkg::A_CONF7;
  endfunction : is_main_grp

  function automatic logic is_ro(input logic [6:0] a);
    return a == gdrv_cfg_pkg::A_CONF3 || a == gdrv_cfg_pkg::A_DTIF ||
           (a >= gdrv_cfg_pkg::A_FLAGA && a <= gdrv_cfg_pkg::A_LINK);
  endfunction : is_ro

  // Bias bits to readout threshold
  function automatic gdrv_cfg_pkg::otp_thr_t thr_of(input logic [1:0] b);
    if (!b[gdrv_cfg_pkg::B_BIAS_EN]) begin
      return gdrv_cfg_pkg::THR_NORMAL;
    end
    return b[gdrv_cfg_pkg::B_BIAS_LV] ? gdrv_cfg_pkg::THR_HIGH : gdrv_cfg_pkg::THR_LOW;
  endfunction : thr_of

  // Pin inputs pass two flops; only the second stage is read
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sync1_q <= 12'h000;
      sync2_q <= 12'h000;
    end else begin
      sync1_q <= {latch_fault, fault_cond_b, fault_cond_a, enable_pin};
      sync2_q <= sync1_q;
    end
  end
  assign en_low = !sync2_q[0];
  assign cond_a = sync2_q[5:1];
  assign cond_b = sync2_q[10:6];
  assign latch_in = sync2_q[11];

  // Access classification
  assign busy = state_q != gdrv_cfg_pkg::ST_IDLE;
  assign load = state_q == gdrv_cfg_pkg::ST_WAIT && otp_rd_done;
  assign wr = acc_req.valid && acc_req.write;
  assign rd = acc_req.valid && !acc_req.write;
  always_comb begin
    fail = !is_mapped(acc_req.addr);
    if (acc_req.write) begin
      fail = fail || is_ro(acc_req.addr);
      fail = fail || (is_otp_grp(acc_req.addr) && otp_lock_q);
      fail = fail || (is_main_grp(acc_req.addr) && main_lock_q);
      fail = fail || (acc_req.addr == gdrv_cfg_pkg::A_DTI && dt_update_busy);
    end
    // Reload path must not be disturbed mid-transfer
    if (busy && (is_otp_grp(acc_req.addr) || acc_req.addr == gdrv_cfg_pkg::A_CONF3 ||
        acc_req.addr == gdrv_cfg_pkg::A_BIAS || (acc_req.write &&
        acc_req.addr == gdrv_cfg_pkg::A_RELOAD))) begin
      fail = 1'b1;
    end
  end
  // Enable-low gating; a refused write here is silent, not a failure
  assign en_ok = en_low || !(acc_req.addr <= gdrv_cfg_pkg::A_CONF7 ||
      acc_req.addr == gdrv_cfg_pkg::A_BIAS || is_otp_grp(acc_req.addr));
  assign wr_ok = wr && !fail && en_ok;

  // Reload sequencer: four words, then held busy until the load time, counted from the start of the reload, has run
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= gdrv_cfg_pkg::ST_REQ; // Startup reload
      word_q <= 2'h0;
      otp_rd_en <= 1'b0;
      thr_q <= gdrv_cfg_pkg::THR_NORMAL;
    end else begin
      case (state_q)
        gdrv_cfg_pkg::ST_IDLE: begin
          if (wr_ok && acc_req.addr == gdrv_cfg_pkg::A_RELOAD &&
              acc_req.wdata == gdrv_cfg_pkg::CMD_GO) begin
            state_q <= gdrv_cfg_pkg::ST_REQ;
            word_q <= 2'h0;
            thr_q <= thr_of(bias_q);
          end
        end
        gdrv_cfg_pkg::ST_REQ: begin
          otp_rd_en <= 1'b1;
          state_q <= gdrv_cfg_pkg::ST_WAIT;
        end
        gdrv_cfg_pkg::ST_WAIT: begin
          if (otp_rd_done) begin
            otp_rd_en <= 1'b0;
            if (word_q == 2'h3) begin
              state_q <= gdrv_cfg_pkg::ST_HOLD;
            end else begin
              word_q <= word_q + 2'h1;
              state_q <= gdrv_cfg_pkg::ST_REQ;
            end
          end
        end
        gdrv_cfg_pkg::ST_HOLD: begin
          if (cnt_q >= gdrv_cfg_pkg::CNT_W'(RELOAD_CYCLES - 1)) begin
            state_q <= gdrv_cfg_pkg::ST_IDLE;
          end
        end
        default: begin
          state_q <= gdrv_cfg_pkg::ST_IDLE;
        end
      endcase
    end
  end
  assign otp_rd_word = word_q;
  assign otp_threshold = thr_q;

  // Busy time counter; saturates so a huge setting cannot wrap
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= '0;
    end else if (!busy) begin
      cnt_q <= '0;
    end else if (cnt_q != '1) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  // OTP-backed config and backup words
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < 3; i++) begin
        prot_q[i] <= gdrv_cfg_pkg::RST_ZERO;
      end
      for (int i = 0; i < 4; i++) begin
        bk_q[i] <= gdrv_cfg_pkg::RST_ZERO;
      end
    end else if (load) begin
      bk_q[word_q] <= otp_rd_data;
      if (word_q != 2'h3) begin
        prot_q[word_q] <= otp_rd_data;
      end
    end else if (wr_ok && acc_req.addr <= gdrv_cfg_pkg::A_CONF2) begin
      prot_q[acc_req.addr[1:0]] <= acc_req.wdata;
    end else if (wr_ok && is_otp_grp(acc_req.addr)) begin
      bk_q[acc_req.addr[1:0]] <= acc_req.wdata;
    end
  end

  // Lock bits only ever set
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      otp_lock_q <= 1'b0;
      main_lock_q <= 1'b0;
    end else begin
      if ((load && word_q == 2'h3 && otp_rd_data[0]) ||
          (wr_ok && acc_req.addr == gdrv_cfg_pkg::A_BK3 && acc_req.wdata[0])) begin
        otp_lock_q <= 1'b1;
      end
      if (wr_ok && acc_req.addr == gdrv_cfg_pkg::A_LOCK && acc_req.wdata[0]) begin
        main_lock_q <= 1'b1;
      end
    end
  end

  // Dynamic registers and the main-lock group
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 4; i < 8; i++) begin
        main_q[i] <= gdrv_cfg_pkg::RST_ZERO;
      end
      aout_sel <= gdrv_cfg_pkg::RST_AOSEL;
      cs_gain <= gdrv_cfg_pkg::RST_ZERO;
      fet_short_lvl <= gdrv_cfg_pkg::RST_ZERO;
      dead_time <= gdrv_cfg_pkg::RST_ZERO;
      bias_q <= 2'h0;
    end else if (wr_ok) begin
      case (acc_req.addr)
        gdrv_cfg_pkg::A_AOSEL: aout_sel <= {5'h00, acc_req.wdata[2:0]};
        gdrv_cfg_pkg::A_CSG: cs_gain <= {6'h00, acc_req.wdata[1:0]};
        gdrv_cfg_pkg::A_FSDL: fet_short_lvl <= {4'h0, acc_req.wdata[3:0]};
        gdrv_cfg_pkg::A_DTI: dead_time <= {4'h0, acc_req.wdata[3:0]};
        gdrv_cfg_pkg::A_BIAS: bias_q <= acc_req.wdata[1:0];
        default: begin
          if (is_main_grp(acc_req.addr)) begin
            main_q[acc_req.addr[2:0]] <= acc_req.wdata;
          end
        end
      endcase
    end
  end

  // Exported config view; slot 3 mirrors the OTP lock
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      cfg_byte[i] = prot_q[i];
    end
    cfg_byte[3] = {7'h00, otp_lock_q};
    for (int i = 4; i < 8; i++) begin
      cfg_byte[i] = main_q[i];
    end
  end
  assign thermal_limit_select = prot_q[0][gdrv_cfg_pkg::B_THERM];
  assign gate_supply_mode_select = prot_q[0][gdrv_cfg_pkg::B_VGSEL];
  assign regulator_level_select = prot_q[0][gdrv_cfg_pkg::B_VCSEL];

  // Fault flags: set wins over any clear in the same cycle
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      flag_a_q <= 5'h00;
      flag_b_q <= 5'h00;
      diagnostic_output_pin_sum_q <= 1'b0;
    end else begin
      if (prot_q[0][gdrv_cfg_pkg::B_CLRSEL]) begin
        flag_a_q <= cond_a;
        flag_b_q <= cond_b;
      end else begin
        flag_a_q <= cond_a | (flag_a_q &
            ~((rd && !fail && acc_req.addr == gdrv_cfg_pkg::A_FLAGA) ? 5'h1F : 5'h00));
        flag_b_q <= cond_b | (flag_b_q &
            ~((rd && !fail && acc_req.addr == gdrv_cfg_pkg::A_FLAGB) ? 5'h1F : 5'h00));
      end
      diagnostic_output_pin_sum_q <= |{flag_a_q, flag_b_q};
    end
  end

  // Latched shutdown and watchdog strobes
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      latch_q <= 1'b0;
      wd_restart <= 1'b0;
      latch_release <= 1'b0;
    end else begin
      wd_restart <= wr_ok && acc_req.addr == gdrv_cfg_pkg::A_WDRST &&
          acc_req.wdata == gdrv_cfg_pkg::CMD_WD;
      latch_release <= wr_ok && acc_req.addr == gdrv_cfg_pkg::A_WDRST &&
          acc_req.wdata == gdrv_cfg_pkg::CMD_UNLATCH;
      if (latch_in) begin
        latch_q <= 1'b1;
      end else if (latch_release) begin
        latch_q <= 1'b0;
      end
    end
  end

  // Diagnostic pin, registered so it never glitches
  assign diagnostic_output_pin_err = prot_q[0][gdrv_cfg_pkg::B_LATONLY] ? latch_q :
      (latch_q || diagnostic_output_pin_sum_q);
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      diagnostic_output_pin <= 1'b1;
    end else begin
      diagnostic_output_pin <= prot_q[0][gdrv_cfg_pkg::B_POL] ? diagnostic_output_pin_err : !diagnostic_output_pin_err;
    end
  end

  // Read mux
  always_comb begin
    rdata = 8'h00;
    case (acc_req.addr)
      gdrv_cfg_pkg::A_CONF3: rdata = {7'h00, otp_lock_q};
      gdrv_cfg_pkg::A_LOCK: rdata = {7'h00, main_lock_q};
      gdrv_cfg_pkg::A_AOSEL: rdata = aout_sel;
      gdrv_cfg_pkg::A_CSG: rdata = cs_gain;
      gdrv_cfg_pkg::A_FSDL: rdata = fet_short_lvl;
      gdrv_cfg_pkg::A_DTI: rdata = dead_time;
      gdrv_cfg_pkg::A_DTIF: rdata = {7'h00, dt_update_busy};
      gdrv_cfg_pkg::A_BIAS: rdata = {6'h00, bias_q};
      gdrv_cfg_pkg::A_FLAGA: rdata = {3'h0, flag_a_q};
      gdrv_cfg_pkg::A_FLAGB: rdata = {3'h0, flag_b_q};
      gdrv_cfg_pkg::A_LINK: rdata = gdrv_cfg_pkg::LINK_PAT;
      default: begin
        if (acc_req.addr <= gdrv_cfg_pkg::A_CONF2) begin
          rdata = prot_q[acc_req.addr[1:0]];
        end else if (is_main_grp(acc_req.addr)) begin
          rdata = main_q[acc_req.addr[2:0]];
        end else if (is_otp_grp(acc_req.addr)) begin
          rdata = bk_q[acc_req.addr[1:0]];
        end
      end
    endcase
  end
  assign status = {1'b0, bias_q[gdrv_cfg_pkg::B_BIAS_EN], acc_fail_q, diagnostic_output_pin_sum_q,
      latch_q, busy, op_mode};

  // Answer one cycle after the request; failure flag covers the last access
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      acc_rsp <= '0;
      acc_fail_q <= 1'b0;
    end else begin
      acc_rsp.valid <= acc_req.valid;
      if (acc_req.valid) begin
        acc_rsp.status <= status;
        acc_rsp.rdata <= (acc_req.write || fail) ? 8'h00 : rdata;
        acc_fail_q <= fail;
      end
    end
  end

  chk_reload_busy: assert property (@(posedge clk) disable iff (!nrst)
    (state_q == gdrv_cfg_pkg::ST_IDLE && wr_ok && acc_req.addr == gdrv_cfg_pkg::A_RELOAD &&
     acc_req.wdata == gdrv_cfg_pkg::CMD_GO) |=> busy ##1 otp_rd_en)
    else $error("reload command did not start a reload");
  chk_reload_thr: assert property (@(posedge clk) disable iff (!nrst)
    otp_rd_en |-> otp_threshold == thr_of(bias_q))
    else $error("readout threshold differs from bias register");
  chk_lock_sticky: assert property (@(posedge clk) disable iff (!nrst)
    (otp_lock_q |=> otp_lock_q) and (main_lock_q |=> main_lock_q))
    else $error("lock bit was cleared");
  chk_locked_write: assert property (@(posedge clk) disable iff (!nrst)
    (wr && main_lock_q && is_main_grp(acc_req.addr)) |=> $stable(main_q[4]) && acc_fail_q)
    else $error("locked register accepted a write");
  chk_en_gate: assert property (@(posedge clk) disable iff (!nrst)
    (wr && !en_low && acc_req.addr == gdrv_cfg_pkg::A_CONF0 && !busy)
    |=> $stable(prot_q[0]))
    else $error("config write taken while enable high");
  chk_unmapped: assert property (@(posedge clk) disable iff (!nrst)
    (acc_req.valid && !is_mapped(acc_req.addr)) |=> acc_fail_q && acc_rsp.valid)
    else $error("unmapped access not flagged");
  chk_flag_recover: assert property (@(posedge clk) disable iff (!nrst)
    (prot_q[0][gdrv_cfg_pkg::B_CLRSEL] && $stable(prot_q[0])) |-> flag_a_q == $past(cond_a))
    else $error("flags do not follow recovery");
  chk_diagnostic_output_pin_pin: assert property (@(posedge clk) disable iff (!nrst)
    (latch_q && prot_q[0][gdrv_cfg_pkg::B_POL]) [*2] |-> diagnostic_output_pin)
    else $error("diagnostic pin not showing latched error");
  // A reload in flight may only end from its hold phase, never because of a poll
  chk_link_read: assert property (@(posedge clk) disable iff (!nrst)
    (rd && acc_req.addr == gdrv_cfg_pkg::A_LINK) |=> acc_rsp.rdata == 8'h55 &&
    (busy || !$past(busy) || $past(state_q) == gdrv_cfg_pkg::ST_HOLD))
    else $error("link check pattern wrong");
  chk_wd_pulse: assert property (@(posedge clk) disable iff (!nrst)
    (wr_ok && acc_req.addr == gdrv_cfg_pkg::A_WDRST && acc_req.wdata == 8'hFF)
    |=> latch_release && !wd_restart)
    else $error("latch release pulse wrong");
  chk_wd_restart: assert property (@(posedge clk) disable iff (!nrst)
    (wr_ok && acc_req.addr == gdrv_cfg_pkg::A_WDRST && acc_req.wdata == 8'h00)
    |=> wd_restart && !latch_release)
    else $error("watchdog restart pulse wrong");
  chk_status_busy: assert property (@(posedge clk) disable iff (!nrst)
    acc_rsp.valid |-> acc_rsp.status[2] == $past(busy))
    else $error("status busy bit wrong");

  cov_reload_done: cover property (@(posedge clk) disable iff (!nrst)
    state_q == gdrv_cfg_pkg::ST_HOLD ##1 state_q == gdrv_cfg_pkg::ST_IDLE);
  cov_otp_lock: cover property (@(posedge clk) disable iff (!nrst) $rose(otp_lock_q));
  cov_fail: cover property (@(posedge clk) disable iff (!nrst) $rose(acc_fail_q));
  cov_high_thr: cover property (@(posedge clk) disable iff (!nrst)
    otp_rd_en && otp_threshold == gdrv_cfg_pkg::THR_HIGH);
endmodule : gdrv_cfg_bank

/* File: otp_model.sv */
// OTP macro stand-in that answers the bank's word read handshake.
// Assumes the bank holds otp_rd_en high until each word is answered.
`timescale 1ns/1ps
module otp_model #(
  parameter logic [31:0] W = 32'h0000_0000
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic slow,
  input wire logic otp_rd_en,
  input wire logic [1:0] otp_rd_word,
  output logic [7:0] otp_rd_data,
  output logic otp_rd_done
);
  logic [1:0] last_q;
  logic [2:0] cnt_q;
  // Answer each new word once; data toggles when no answer so stale bytes never pass
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      last_q <= 2'h3;
      cnt_q <= 3'h0;
      otp_rd_done <= 1'b0;
      otp_rd_data <= 8'hA5;
    end else begin
      otp_rd_done <= 1'b0;
      otp_rd_data <= ~otp_rd_data;
      if (otp_rd_en && otp_rd_word != last_q && !otp_rd_done) begin
        if (cnt_q >= (slow ? 3'h3 : 3'h0)) begin
          otp_rd_done <= 1'b1;
          otp_rd_data <= W[8*otp_rd_word+:8];
          last_q <= otp_rd_word;
          cnt_q <= 3'h0;
        end else begin
          cnt_q <= cnt_q + 3'h1;
        end
      end
    end
  end
endmodule : otp_model

/* File: gate_driver_config_register_bank_tb.sv */
// Self-checking bench for the configuration bank with a register model.
// Assumes the bank and the OTP stand-in share one 100 MHz clock.
`timescale 1ns/1ps
module gate_driver_config_register_bank_tb;
  localparam logic [31:0] OTPW = 32'h002A_152D;
  logic clk, nrst, slow, en, latf, otp_rd_en, otp_rd_done, pin, wdr, lrel;
  logic [1:0] mode, otp_rd_word;
  logic [4:0] fca, fcb;
  logic [7:0] otp_rd_data, fexp;
  logic [7:0] cfg_byte [0:7];
  logic [7:0] mdl [0:127];
  logic ol, ml, lf, tsel, gsel, rsel;
  gdrv_cfg_pkg::acc_req_t acc_req;
  gdrv_cfg_pkg::acc_rsp_t acc_rsp;
  gdrv_cfg_pkg::otp_thr_t thr;
  int seed = 95;
  int n_fail = 0;
  int num_checks = 0;
  // Short reload count keeps each busy window to a few dozen cycles
  gdrv_cfg_bank #(.RELOAD_CYCLES(20)) dut (.clk(clk), .nrst(nrst), .acc_req(acc_req),
    .acc_rsp(acc_rsp), .op_mode(mode), .dt_update_busy(1'b0), .enable_pin(en),
    .fault_cond_a(fca), .fault_cond_b(fcb), .latch_fault(latf), .otp_rd_en(otp_rd_en),
    .otp_rd_word(otp_rd_word), .otp_threshold(thr), .otp_rd_data(otp_rd_data),
    .otp_rd_done(otp_rd_done), .cfg_byte(cfg_byte), .aout_sel(), .cs_gain(),
    .fet_short_lvl(), .dead_time(), .thermal_limit_select(tsel),
    .gate_supply_mode_select(gsel), .regulator_level_select(rsel),
    .diagnostic_output_pin(pin), .wd_restart(wdr), .latch_release(lrel));
  otp_model #(.W(OTPW)) otp (.clk(clk), .nrst(nrst), .slow(slow), .otp_rd_en(otp_rd_en),
    .otp_rd_word(otp_rd_word), .otp_rd_data(otp_rd_data), .otp_rd_done(otp_rd_done));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic close_out();
    if (n_fail == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : close_out
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Model side: which accesses are refused and what a good read returns
  function automatic logic bad(input logic w, input logic [6:0] a);
    logic um;
    um = !(a <= 7'h08 || a inside {[7'h10:7'h17], [7'h20:7'h22], [7'h40:7'h43]});
    return um || (w && a inside {7'h03, 7'h14, [7'h20:7'h22]})
      || (w && ol && (a <= 7'h02 || a inside {[7'h40:7'h43]}))
      || (w && ml && a inside {[7'h04:7'h07]});
  endfunction : bad
  function automatic logic [7:0] exp_rd(input logic [6:0] a);
    case (a)
      7'h03: return {7'h00, ol};
      7'h08: return {7'h00, ml};
      7'h14, 7'h15, 7'h17: return 8'h00;
      7'h20: return fexp;
      7'h22: return 8'h55;
      default: return mdl[a];
    endcase
  endfunction : exp_rd
  // One register access; the answer is checked on the cycle it stands
  task automatic acc(input logic w, input logic [6:0] a, input logic [7:0] d);
    logic f;
    f = bad(w, a);
    @(negedge clk);
    acc_req <= '{valid: 1'b1, write: w, addr: a, wdata: d};
    @(negedge clk);
    acc_req.valid <= 1'b0;
    chk("rsp_valid", 8'h01, {7'h00, acc_rsp.valid});
    chk("status", {2'b00, lf, 3'b000, mode}, acc_rsp.status & 8'h23);
    if (!w) chk("rdata", f ? 8'h00 : exp_rd(a), acc_rsp.rdata);
    if (w && a == 7'h15) chk("pulse", {6'h00, d == 8'hFF, d == 8'h00}, {6'h00, lrel, wdr});
    if (w && !f && !(en && (a <= 7'h07 || a inside {7'h16, [7'h40:7'h43]}))) begin
      if (a == 7'h08) ml = ml | d[0];
      else if (a != 7'h15 && a != 7'h17) mdl[a] = d;
      if (a == 7'h43) ol = ol | d[0];
    end
    lf = f;
  endtask : acc
  task automatic poll();
    int i;
    i = 0;
    acc(1'b0, 7'h22, 8'h00);
    chk("busy", 8'h04, acc_rsp.status & 8'h04);
    while (acc_rsp.status[2] !== 1'b0 && i < 100) begin
      acc(1'b0, 7'h22, 8'h00);
      i++;
    end
    chk("idle", 8'h00, acc_rsp.status & 8'h04);
    for (int k = 0; k < 4; k++) begin
      if (k < 3) mdl[k] = OTPW[8*k+:8];
      mdl[7'h40+k] = OTPW[8*k+:8];
    end
    ol = ol | OTPW[24];
  endtask : poll
  task automatic reload(input logic [1:0] bias, input logic slw);
    slow = slw;
    acc(1'b1, 7'h16, {6'h00, bias});
    acc(1'b1, 7'h17, 8'h00);
    @(negedge clk);
    chk("thr", bias == 2'b10 ? 8'h01 : bias == 2'b11 ? 8'h02 : 8'h00, {6'h00, thr});
    poll();
    for (int k = 0; k < 4; k++) begin
      chk("cfg", k == 3 ? {7'h00, ol} : mdl[k], cfg_byte[k]);
      acc(1'b0, k[6:0], 8'h00);
      acc(1'b0, 7'h40 + k[6:0], 8'h00);
    end
  endtask : reload
  initial begin
    #200us;
    n_fail++;
    close_out();
  end
  initial begin
    logic [7:0] d;
    foreach (mdl[i]) mdl[i] = 8'h00;
    mdl[7'h10] = 8'h07;
    {ol, ml, lf, slow, en, latf, fca, fcb, fexp} = '0;
    acc_req = '0;
    nrst = 1'b0;
    mode = 2'($random(seed));
    repeat (20) @(negedge clk);
    nrst = 1'b1;
    acc(1'b0, 7'h10, 8'h00);
    acc(1'b0, 7'h08, 8'h00);
    poll();
    // Margin sequence: low, high, then normal threshold
    reload(2'b10, 1'b0);
    reload(2'b11, 1'b1);
    reload(2'b00, 1'b0);
    en = 1'b1;
    repeat (4) @(negedge clk);
    acc(1'b1, 7'h00, 8'h21);
    acc(1'b0, 7'h00, 8'h00);
    en = 1'b0;
    repeat (4) @(negedge clk);
    acc(1'b1, 7'h00, 8'h00);
    fca = 5'h01;
    repeat (6) @(negedge clk);
    chk("pin", 8'h00, {7'h00, pin});
    fca = 5'h00;
    repeat (6) @(negedge clk);
    fexp = 8'h01;
    acc(1'b0, 7'h20, 8'h00);
    fexp = 8'h00;
    acc(1'b0, 7'h20, 8'h00);
    d = (8'($random(seed)) & 8'h23) | 8'h1C;
    acc(1'b1, 7'h00, d);
    chk("sel", {5'h00, d[5], d[1], d[0]}, {5'h00, tsel, gsel, rsel});
    fcb = 5'h02;
    repeat (6) @(negedge clk);
    chk("pin", 8'h00, {7'h00, pin});
    // Flags now follow the condition, so the read shows it while it lasts
    mdl[7'h21] = 8'h02;
    acc(1'b0, 7'h21, 8'h00);
    latf = 1'b1;
    repeat (6) @(negedge clk);
    chk("pin", 8'h01, {7'h00, pin});
    latf = 1'b0;
    fcb = 5'h00;
    acc(1'b1, 7'h15, 8'hFF);
    acc(1'b1, 7'h15, 8'h00);
    mdl[7'h21] = 8'h00;
    acc(1'b0, 7'h21, 8'h00);
    // Only the zero code starts a reload; any other byte leaves the bank idle
    acc(1'b1, 7'h17, 8'h5A);
    acc(1'b0, 7'h22, 8'h00);
    chk("busy", 8'h00, acc_rsp.status & 8'h04);
    acc(1'b0, 7'h30, 8'h00);
    acc(1'b1, 7'h7F, 8'h12);
    acc(1'b1, 7'h14, 8'h01);
    acc(1'b1, 7'h08, 8'h01);
    acc(1'b1, 7'h04, 8'hAA);
    acc(1'b1, 7'h08, 8'h00);
    acc(1'b0, 7'h08, 8'h00);
    acc(1'b1, 7'h43, 8'h01);
    acc(1'b1, 7'h00, 8'h3F);
    reload(2'b00, 1'b1);
    acc(1'b1, 7'h41, 8'h00);
    acc(1'b0, 7'h41, 8'h00);
    close_out();
  end
endmodule : gate_driver_config_register_bank_tb
